/* verilog/cmpc_regs.sv */
// Comparator control and status register bank on the special function register bus.
// Function
// - Mode register unused bits read zero.
// - Rising enable gates rising interrupt request.
// - Falling enable gates falling interrupt request.
// - Mode bits pick one of four responses.
// - Mode resets to code 10, enables zero.
// - Comparator powered only while enabled.
// - Control bit 6 shows live output.
// - Rising edge sets sticky flag until cleared.
// - Falling edge sets sticky flag until cleared.
// - Bits 3:2 hold positive hysteresis code.
// - Bits 1:0 hold negative hysteresis code.
// - Per-comparator positive and negative pin selects.
// - Select codes 1100 to 1111 choose no pin.
// - Both multiplexers may share a pin.
// - Disabled comparator drives routed output low.
`timescale 1ns/10ps
module cmpc_regs (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic cmp_a_rise_flag,
	input wire logic cmp_a_fall_flag,
	input wire logic cmp_b_raw_out,
	output logic [1:0] cmp_a_response_mode,
	output logic [1:0] cmp_b_response_mode,
	output logic cmp_b_enable,
	output logic [1:0] cmp_b_pos_hysteresis,
	output logic [1:0] cmp_b_neg_hysteresis,
	output logic cmp_b_pin_out,
	output logic [11:0] cmp_a_pos_pin,
	output logic [11:0] cmp_a_neg_pin,
	output logic [11:0] cmp_b_pos_pin,
	output logic [11:0] cmp_b_neg_pin,
	output logic cmp_a_irq,
	output logic cmp_b_irq
);
	// Turns a four-bit select into a one-hot pin connection; codes past the pins give none.
	function automatic logic [11:0] cmpc_pin_decode(input logic [3:0] code);
		logic [11:0] hot;
		hot = 12'h000;
		if (code < 4'hC) begin
			hot[code] = 1'b1;
		end
		return hot;
	endfunction

	cmpc_edge_if eif ();

	logic wr_a_mode, wr_b_mode, wr_b_ctrl, wr_a_mux, wr_b_mux;
	logic a_rie, a_fie, b_rie, b_fie;
	logic [7:0] a_mode_rd, b_mode_rd, b_ctrl_rd, rd_sel;
	logic en_q, en_d;
	logic [1:0] hyp_q, hyp_d, hyn_q, hyn_d;
	logic [7:0] a_mux_q, a_mux_d, b_mux_q, b_mux_d;
	logic [7:0] rdata_q, rdata_d;
	logic a_irq_q, a_irq_d, b_irq_q, b_irq_d, pin_q, pin_d;
	logic [11:0] a_pos_q, a_pos_d, a_neg_q, a_neg_d, b_pos_q, b_pos_d, b_neg_q, b_neg_d;

	// Address decode of writes; each register owns one offset.
	assign wr_a_mode = sfr_wr && (sfr_addr == cmpc_pkg::CMPC_A_MODE_ADDR);
	assign wr_b_mode = sfr_wr && (sfr_addr == cmpc_pkg::CMPC_B_MODE_ADDR);
	assign wr_b_ctrl = sfr_wr && (sfr_addr == cmpc_pkg::CMPC_B_CTRL_ADDR);
	assign wr_a_mux = sfr_wr && (sfr_addr == cmpc_pkg::CMPC_A_MUX_ADDR);
	assign wr_b_mux = sfr_wr && (sfr_addr == cmpc_pkg::CMPC_B_MUX_ADDR);

	// The two mode registers are identical, so each is one instance.
	cmpc_mode_reg u_a_mode (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.wr(wr_a_mode),
		.wdata(sfr_wdata),
		.rise_irq_en(a_rie),
		.fall_irq_en(a_fie),
		.response_mode(cmp_a_response_mode),
		.rdata(a_mode_rd)
	);

	cmpc_mode_reg u_b_mode (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.wr(wr_b_mode),
		.wdata(sfr_wdata),
		.rise_irq_en(b_rie),
		.fall_irq_en(b_fie),
		.response_mode(cmp_b_response_mode),
		.rdata(b_mode_rd)
	);

	// Edge flags live beside the synchroniser; writes to their bits pass through.
	assign eif.enable = en_q;
	assign eif.wr_ctrl = wr_b_ctrl;
	assign eif.wr_rise = wr_b_ctrl;
	assign eif.wr_fall = wr_b_ctrl;

	cmpc_edge_capture u_edge (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.raw_out(cmp_b_raw_out),
		.wdata(sfr_wdata),
		.eif(eif.cap)
	);

	// Stored control and multiplexer fields.
	always_comb begin
		en_d = en_q;
		hyp_d = hyp_q;
		hyn_d = hyn_q;
		a_mux_d = a_mux_q;
		b_mux_d = b_mux_q;
		if (wr_b_ctrl) begin
			en_d = sfr_wdata[cmpc_pkg::CMPC_CTRL_EN_BIT];
			hyp_d = sfr_wdata[cmpc_pkg::CMPC_CTRL_HYP_LSB +: 2];
			hyn_d = sfr_wdata[cmpc_pkg::CMPC_CTRL_HYN_LSB +: 2];
		end
		if (wr_a_mux) begin
			a_mux_d = sfr_wdata;
		end
		if (wr_b_mux) begin
			b_mux_d = sfr_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			en_q <= 1'b0;
			hyp_q <= cmpc_pkg::CMPC_HYST_RST;
			hyn_q <= cmpc_pkg::CMPC_HYST_RST;
			a_mux_q <= cmpc_pkg::CMPC_MUX_RST;
			b_mux_q <= cmpc_pkg::CMPC_MUX_RST;
		end else begin
			en_q <= en_d;
			hyp_q <= hyp_d;
			hyn_q <= hyn_d;
			a_mux_q <= a_mux_d;
			b_mux_q <= b_mux_d;
		end
	end

	// Control register read image; bit 6 is the live synchronised output.
	always_comb begin
		b_ctrl_rd = 8'h00;
		b_ctrl_rd[cmpc_pkg::CMPC_CTRL_EN_BIT] = en_q;
		b_ctrl_rd[cmpc_pkg::CMPC_CTRL_OUT_BIT] = eif.out_state;
		b_ctrl_rd[cmpc_pkg::CMPC_CTRL_RIF_BIT] = eif.rise_flag;
		b_ctrl_rd[cmpc_pkg::CMPC_CTRL_FIF_BIT] = eif.fall_flag;
		b_ctrl_rd[cmpc_pkg::CMPC_CTRL_HYP_LSB +: 2] = hyp_q;
		b_ctrl_rd[cmpc_pkg::CMPC_CTRL_HYN_LSB +: 2] = hyn_q;
	end

	// Read mux; an unmapped offset answers zero rather than stale data.
	always_comb begin
		case (sfr_addr)
			cmpc_pkg::CMPC_A_MODE_ADDR: rd_sel = a_mode_rd;
			cmpc_pkg::CMPC_A_MUX_ADDR: rd_sel = a_mux_q;
			cmpc_pkg::CMPC_B_CTRL_ADDR: rd_sel = b_ctrl_rd;
			cmpc_pkg::CMPC_B_MODE_ADDR: rd_sel = b_mode_rd;
			cmpc_pkg::CMPC_B_MUX_ADDR: rd_sel = b_mux_q;
			default: rd_sel = cmpc_pkg::CMPC_READ_NONE;
		endcase
	end

	// Next values of the registered outputs: read data, requests, routed pin, pin selects.
	always_comb begin
		rdata_d = rdata_q;
		if (sfr_rd) begin
			rdata_d = rd_sel;
		end
		a_irq_d = (cmp_a_rise_flag & a_rie) | (cmp_a_fall_flag & a_fie);
		b_irq_d = (eif.rise_flag & b_rie) | (eif.fall_flag & b_fie);
		pin_d = eif.out_state & en_q;
		// Each decoder reads only its own register, so a shared pin is legal.
		a_pos_d = cmpc_pin_decode(a_mux_q[cmpc_pkg::CMPC_MUX_POS_LSB +: 4]);
		a_neg_d = cmpc_pin_decode(a_mux_q[cmpc_pkg::CMPC_MUX_NEG_LSB +: 4]);
		b_pos_d = cmpc_pin_decode(b_mux_q[cmpc_pkg::CMPC_MUX_POS_LSB +: 4]);
		b_neg_d = cmpc_pin_decode(b_mux_q[cmpc_pkg::CMPC_MUX_NEG_LSB +: 4]);
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
			a_irq_q <= 1'b0;
			b_irq_q <= 1'b0;
			pin_q <= 1'b0;
			a_pos_q <= 12'h000;
			a_neg_q <= 12'h000;
			b_pos_q <= 12'h000;
			b_neg_q <= 12'h000;
		end else begin
			rdata_q <= rdata_d;
			a_irq_q <= a_irq_d;
			b_irq_q <= b_irq_d;
			pin_q <= pin_d;
			a_pos_q <= a_pos_d;
			a_neg_q <= a_neg_d;
			b_pos_q <= b_pos_d;
			b_neg_q <= b_neg_d;
		end
	end

	// Analog-facing controls come straight from their registers.
	assign sfr_rdata = rdata_q;
	assign cmp_b_enable = en_q;
	assign cmp_b_pos_hysteresis = hyp_q;
	assign cmp_b_neg_hysteresis = hyn_q;
	assign cmp_b_pin_out = pin_q;
	assign cmp_a_pos_pin = a_pos_q;
	assign cmp_a_neg_pin = a_neg_q;
	assign cmp_b_pos_pin = b_pos_q;
	assign cmp_b_neg_pin = b_neg_q;
	assign cmp_a_irq = a_irq_q;
	assign cmp_b_irq = b_irq_q;

	property p_rise_irq;
		@(posedge sys_clk) disable iff (sys_rst)
		eif.rise_flag && b_rie |=> cmp_b_irq;
	endproperty
	a_rise_irq: assert property (p_rise_irq) else $error("Enabled rising flag gave no request.");

	property p_fall_irq;
		@(posedge sys_clk) disable iff (sys_rst)
		cmp_a_fall_flag && a_fie |=> cmp_a_irq;
	endproperty
	a_fall_irq: assert property (p_fall_irq) else $error("Enabled falling flag gave no request.");

	property p_irq_gated;
		@(posedge sys_clk) disable iff (sys_rst)
		!(eif.rise_flag && b_rie) && !(eif.fall_flag && b_fie) |=> !cmp_b_irq;
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("Request without enabled flag.");

	property p_disabled_low;
		@(posedge sys_clk) disable iff (sys_rst)
		!cmp_b_enable |=> !cmp_b_pin_out;
	endproperty
	a_disabled_low: assert property (p_disabled_low) else $error("Disabled pin output high.");

	property p_none_select;
		@(posedge sys_clk) disable iff (sys_rst)
		b_mux_q[3:2] == 2'h3 |=> b_pos_q == 12'h000;
	endproperty
	a_none_select: assert property (p_none_select) else $error("High code connected a pin.");

	property p_hyst_write;
		@(posedge sys_clk) disable iff (sys_rst)
		wr_b_ctrl |=> (cmp_b_pos_hysteresis == $past(sfr_wdata[3:2]))
			&& (cmp_b_neg_hysteresis == $past(sfr_wdata[1:0])) && (cmp_b_enable == $past(sfr_wdata[7]));
	endproperty
	a_hyst_write: assert property (p_hyst_write) else $error("Control write lost.");

	property p_shared_pin;
		@(posedge sys_clk) disable iff (sys_rst)
		(a_mux_q[3:0] == b_mux_q[3:0]) && (a_mux_q[3:0] < 4'hC) |=> (a_pos_q == b_pos_q) && (a_pos_q != 12'h000);
	endproperty
	a_shared_pin: assert property (p_shared_pin) else $error("Shared pin select blocked.");

	property p_read_unmapped;
		@(posedge sys_clk) disable iff (sys_rst)
		sfr_rd && (sfr_addr == 8'h9A) |=> sfr_rdata == 8'h00;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("Unmapped read not zero.");

	property p_a_rise_irq;
		@(posedge sys_clk) disable iff (sys_rst)
		cmp_a_rise_flag && a_rie |=> cmp_a_irq;
	endproperty
	a_a_rise_irq: assert property (p_a_rise_irq) else $error("Enabled A rising flag no request.");

	property p_b_fall_irq;
		@(posedge sys_clk) disable iff (sys_rst)
		eif.fall_flag && b_fie |=> cmp_b_irq;
	endproperty
	a_b_fall_irq: assert property (p_b_fall_irq) else $error("Enabled B falling flag no request.");

	property p_a_irq_gated;
		@(posedge sys_clk) disable iff (sys_rst)
		!(cmp_a_rise_flag && a_rie) && !(cmp_a_fall_flag && a_fie) |=> !cmp_a_irq;
	endproperty
	a_a_irq_gated: assert property (p_a_irq_gated) else $error("A request without enabled flag.");

	// While enabled the routed pin must track the synchronised output, not stick low.
	property p_enabled_follows;
		@(posedge sys_clk) disable iff (sys_rst)
		cmp_b_enable |=> cmp_b_pin_out == $past(eif.out_state);
	endproperty
	a_enabled_follows: assert property (p_enabled_follows) else $error("Pin lost output.");

	property p_a_neg_none;
		@(posedge sys_clk) disable iff (sys_rst)
		a_mux_q[7:6] == 2'h3 |=> a_neg_q == 12'h000;
	endproperty
	a_a_neg_none: assert property (p_a_neg_none) else $error("High negative code connected a pin.");

	property p_ctrl_out_bit;
		@(posedge sys_clk) disable iff (sys_rst)
		sfr_rd && (sfr_addr == cmpc_pkg::CMPC_B_CTRL_ADDR)
			|=> sfr_rdata[cmpc_pkg::CMPC_CTRL_OUT_BIT] == $past(eif.out_state);
	endproperty
	a_ctrl_out_bit: assert property (p_ctrl_out_bit) else $error("Status bit not live output.");

	c_b_irq: cover property (@(posedge sys_clk) disable iff (sys_rst) !cmp_b_irq ##1 cmp_b_irq);
	c_enable: cover property (@(posedge sys_clk) disable iff (sys_rst) wr_b_ctrl ##1 cmp_b_enable);
	c_shared: cover property (@(posedge sys_clk) disable iff (sys_rst)
		(a_pos_q == b_pos_q) && (a_pos_q != 12'h000));
endmodule // cmpc_regs

/* verilog/cmpc_pkg.sv */
// Package with register offsets, field positions and reset values of the comparator control bank.
package cmpc_pkg;
	// Register offsets on the special function register bus.
	localparam logic [7:0] CMPC_A_MODE_ADDR = 8'h9B;
	localparam logic [7:0] CMPC_A_MUX_ADDR = 8'h9C;
	localparam logic [7:0] CMPC_B_CTRL_ADDR = 8'h9D;
	localparam logic [7:0] CMPC_B_MODE_ADDR = 8'h9E;
	localparam logic [7:0] CMPC_B_MUX_ADDR = 8'h9F;
	// Mode register fields.
	localparam int CMPC_MODE_RIE_BIT = 5;
	localparam int CMPC_MODE_FIE_BIT = 4;
	localparam int CMPC_MODE_RESP_LSB = 0;
	localparam logic [1:0] CMPC_RESP_RST = 2'h2;
	// Control register fields.
	localparam int CMPC_CTRL_EN_BIT = 7;
	localparam int CMPC_CTRL_OUT_BIT = 6;
	localparam int CMPC_CTRL_RIF_BIT = 5;
	localparam int CMPC_CTRL_FIF_BIT = 4;
	localparam int CMPC_CTRL_HYP_LSB = 2;
	localparam int CMPC_CTRL_HYN_LSB = 0;
	localparam logic [1:0] CMPC_HYST_RST = 2'h0;
	// Multiplexer select fields, reset value and pin count.
	localparam int CMPC_MUX_POS_LSB = 0;
	localparam int CMPC_MUX_NEG_LSB = 4;
	localparam logic [7:0] CMPC_MUX_RST = 8'h77;
	localparam int CMPC_NUM_PINS = 12;
	localparam logic [7:0] CMPC_READ_NONE = 8'h00;
endpackage

/* verilog/cmpc_edge_if.sv */
// Interface between the register bank and the edge capture of comparator B.
`timescale 1ns/10ps
interface cmpc_edge_if;
	logic enable;
	logic wr_ctrl;
	logic wr_rise;
	logic wr_fall;
	logic rise_flag;
	logic fall_flag;
	logic out_state;
	modport bank (output enable, output wr_ctrl, output wr_rise, output wr_fall,
		input rise_flag, input fall_flag, input out_state);
	modport cap (input enable, input wr_ctrl, input wr_rise, input wr_fall,
		output rise_flag, output fall_flag, output out_state);
endinterface

/* verilog/cmpc_mode_reg.sv */
// One comparator mode register: interrupt enables and response mode.
`timescale 1ns/10ps
module cmpc_mode_reg (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic wr,
	input wire logic [7:0] wdata,
	output logic rise_irq_en,
	output logic fall_irq_en,
	output logic [1:0] response_mode,
	output logic [7:0] rdata
);
	logic rie_q, rie_d, fie_q, fie_d;
	logic [1:0] resp_q, resp_d;

	// Only the enable and mode bits are stored; other written bits are dropped.
	always_comb begin
		rie_d = rie_q;
		fie_d = fie_q;
		resp_d = resp_q;
		if (wr) begin
			rie_d = wdata[cmpc_pkg::CMPC_MODE_RIE_BIT];
			fie_d = wdata[cmpc_pkg::CMPC_MODE_FIE_BIT];
			resp_d = wdata[cmpc_pkg::CMPC_MODE_RESP_LSB +: 2];
		end
	end

	// Reset loads mode 2 with both interrupts off.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rie_q <= 1'b0;
			fie_q <= 1'b0;
			resp_q <= cmpc_pkg::CMPC_RESP_RST;
		end else begin
			rie_q <= rie_d;
			fie_q <= fie_d;
			resp_q <= resp_d;
		end
	end

	// Unused bits 7:6 and 3:2 always read zero.
	always_comb begin
		rdata = 8'h00;
		rdata[cmpc_pkg::CMPC_MODE_RIE_BIT] = rie_q;
		rdata[cmpc_pkg::CMPC_MODE_FIE_BIT] = fie_q;
		rdata[cmpc_pkg::CMPC_MODE_RESP_LSB +: 2] = resp_q;
	end

	assign rise_irq_en = rie_q;
	assign fall_irq_en = fie_q;
	assign response_mode = resp_q;

	property p_mode_unused_zero;
		@(posedge sys_clk) disable iff (sys_rst)
		(rdata[7:6] == 2'h0) && (rdata[3:2] == 2'h0);
	endproperty
	a_mode_unused_zero: assert property (p_mode_unused_zero) else $error("Unused mode bits not zero.");

	property p_mode_write_takes;
		@(posedge sys_clk) disable iff (sys_rst)
		wr |=> (response_mode == $past(wdata[1:0])) && (rise_irq_en == $past(wdata[5]))
			&& (fall_irq_en == $past(wdata[4]));
	endproperty
	a_mode_write_takes: assert property (p_mode_write_takes) else $error("Mode write lost.");
endmodule // cmpc_mode_reg

/* verilog/cmpc_edge_capture.sv */
// Synchroniser, output state and sticky edge flags of comparator B.
`timescale 1ns/10ps
module cmpc_edge_capture (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic raw_out,
	input wire logic [7:0] wdata,
	cmpc_edge_if.cap eif
);
	logic sync1_q, sync2_q, prev_q, rif_q, rif_d, fif_q, fif_d;
	logic live, rise_evt, fall_evt;

	// A disabled comparator reads low, so enabling it can itself look like an edge.
	assign live = sync2_q & eif.enable;
	assign rise_evt = live & ~prev_q;
	assign fall_evt = ~live & prev_q;

	// An edge in the same cycle as a software write wins over the clear.
	always_comb begin
		rif_d = rif_q;
		fif_d = fif_q;
		if (eif.wr_rise) begin
			rif_d = wdata[cmpc_pkg::CMPC_CTRL_RIF_BIT];
		end
		if (eif.wr_fall) begin
			fif_d = wdata[cmpc_pkg::CMPC_CTRL_FIF_BIT];
		end
		if (rise_evt) begin
			rif_d = 1'b1;
		end
		if (fall_evt) begin
			fif_d = 1'b1;
		end
	end

	// The first stage is read only by the second stage.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
			rif_q <= 1'b0;
			fif_q <= 1'b0;
		end else begin
			sync1_q <= raw_out;
			sync2_q <= sync1_q;
			prev_q <= live;
			rif_q <= rif_d;
			fif_q <= fif_d;
		end
	end

	assign eif.rise_flag = rif_q;
	assign eif.fall_flag = fif_q;
	assign eif.out_state = prev_q;

	property p_rise_sets;
		@(posedge sys_clk) disable iff (sys_rst)
		rise_evt |=> rif_q;
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("Rising edge flag not set.");

	property p_fall_sets;
		@(posedge sys_clk) disable iff (sys_rst)
		fall_evt |=> fif_q;
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("Falling edge flag not set.");

	property p_rise_sticky;
		@(posedge sys_clk) disable iff (sys_rst)
		rif_q && !eif.wr_ctrl |=> rif_q;
	endproperty
	a_rise_sticky: assert property (p_rise_sticky) else $error("Rising flag dropped alone.");

	property p_fall_sticky;
		@(posedge sys_clk) disable iff (sys_rst)
		fif_q && !eif.wr_ctrl |=> fif_q;
	endproperty
	a_fall_sticky: assert property (p_fall_sticky) else $error("Falling flag dropped alone.");

	c_rise_seen: cover property (@(posedge sys_clk) disable iff (sys_rst) rise_evt ##1 rif_q);
	c_set_beats_clear: cover property (@(posedge sys_clk) disable iff (sys_rst)
		eif.wr_ctrl && rise_evt);
endmodule // cmpc_edge_capture

/* dv/cmpc_analog_model.sv */
// Behavioural model of the analog core of comparator B that feeds the register bank.
`timescale 1ns/10ps
module cmpc_analog_model (
	input wire logic enable,
	input wire logic pos_gt_neg,
	output logic raw_out
);
	// An unpowered comparator cannot resolve its inputs, so its raw output rests low.
	assign raw_out = enable & pos_gt_neg;
endmodule // cmpc_analog_model

/* dv/test_cmpc_regs.sv */
// Self-checking testbench for the comparator control register bank.
`timescale 1ns/10ps
module test_cmpc_regs;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic cmp_a_rise_flag = 1'b0;
	logic cmp_a_fall_flag = 1'b0;
	logic pos_gt_neg = 1'b0;
	logic [7:0] sfr_rdata;
	logic cmp_b_raw_out, cmp_b_enable, cmp_b_pin_out, cmp_a_irq, cmp_b_irq;
	logic [1:0] cmp_a_response_mode, cmp_b_response_mode;
	logic [1:0] cmp_b_pos_hysteresis, cmp_b_neg_hysteresis;
	logic [11:0] cmp_a_pos_pin, cmp_a_neg_pin, cmp_b_pos_pin, cmp_b_neg_pin;
	logic [11:0] exp_pin;
	int error_cnt = 0;
	int check_count = 0;
	int cycle_cnt = 0;

	cmpc_regs i_dut (.sys_clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
		.sfr_rdata, .cmp_a_rise_flag, .cmp_a_fall_flag, .cmp_b_raw_out,
		.cmp_a_response_mode, .cmp_b_response_mode, .cmp_b_enable,
		.cmp_b_pos_hysteresis, .cmp_b_neg_hysteresis, .cmp_b_pin_out,
		.cmp_a_pos_pin, .cmp_a_neg_pin, .cmp_b_pos_pin, .cmp_b_neg_pin,
		.cmp_a_irq, .cmp_b_irq);

	cmpc_analog_model i_analog (.enable(cmp_b_enable), .pos_gt_neg(pos_gt_neg),
		.raw_out(cmp_b_raw_out));

	// The 25 MHz system clock.
	always #20 sys_clk = ~sys_clk;

	// A hung handshake would stall the run, so a cycle ceiling cuts it short.
	always @(posedge sys_clk) begin
		cycle_cnt++;
		if (cycle_cnt == 3000) begin
			error_cnt++;
			$display("[ERR] %0t ns: run did not finish in time", $time);
			close_out();
		end
	end

	task automatic close_out;
		$display("Comparisons: %0d, mismatches: %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Writes are one-cycle strobes launched at the falling edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge sys_clk);
		sfr_wr = 1'b0;
	endtask

	// Read data is registered, so it is sampled one full cycle after the strobe.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge sys_clk);
		sfr_rd = 1'b0;
		@(negedge sys_clk);
		chk({4'h0, sfr_rdata}, {4'h0, exp});
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// Main sequence of tests.
	initial begin
		idle(2);
		sys_rst = 1'b0;
		idle(2);
		rd(8'h9B, 8'h02);
		rd(8'h9E, 8'h02);
		rd(8'h9D, 8'h00);
		chk({10'h000, cmp_a_response_mode}, 12'h002);
		chk({10'h000, cmp_b_response_mode}, 12'h002);
		chk({11'h000, cmp_b_enable}, 12'h000);
		chk(cmp_a_pos_pin, 12'h080);
		chk(cmp_b_neg_pin, 12'h080);
		$display("Test reset values done");

		// Unused bits are written as ones and must read back as zero.
		for (int m = 0; m < 4; m++) begin
			wr(8'h9B, {2'b11, m[1:0], 2'b11, m[1:0]});
			wr(8'h9E, {2'b11, ~m[1:0], 2'b11, ~m[1:0]});
			rd(8'h9B, {2'b00, m[1:0], 2'b00, m[1:0]});
			rd(8'h9E, {2'b00, ~m[1:0], 2'b00, ~m[1:0]});
			chk({10'h000, cmp_a_response_mode}, {10'h000, m[1:0]});
			chk({10'h000, cmp_b_response_mode}, {10'h000, ~m[1:0]});
		end
		wr(8'h9A, 8'hFF);
		rd(8'h9A, 8'h00);
		rd(8'hA0, 8'h00);
		$display("Test mode registers done");

		// Every select code on both multiplexers at once, including the no-pin codes.
		for (int k = 0; k < 16; k++) begin
			wr(8'h9C, {k[3:0], k[3:0]});
			wr(8'h9F, {k[3:0], k[3:0]});
			idle(3);
			exp_pin = (k < 12) ? (12'h001 << k) : 12'h000;
			chk(cmp_a_pos_pin, exp_pin);
			chk(cmp_a_neg_pin, exp_pin);
			chk(cmp_b_pos_pin, exp_pin);
			chk(cmp_b_neg_pin, exp_pin);
		end
		// Port setup outside this block is taken to leave chosen pins analog and skipped.
		wr(8'h9C, 8'h5B);
		idle(3);
		chk(cmp_a_pos_pin, 12'h800);
		chk(cmp_a_neg_pin, 12'h020);
		rd(8'h9C, 8'h5B);
		$display("Test multiplexers done");

		// Comparator A requests follow its flags through the enables.
		wr(8'h9B, 8'h20);
		cmp_a_rise_flag = 1'b1;
		idle(2);
		chk({11'h000, cmp_a_irq}, 12'h001);
		cmp_a_rise_flag = 1'b0;
		cmp_a_fall_flag = 1'b1;
		idle(2);
		chk({11'h000, cmp_a_irq}, 12'h000);
		wr(8'h9B, 8'h10);
		idle(1);
		chk({11'h000, cmp_a_irq}, 12'h001);
		$display("Test comparator A requests done");

		// Comparator B: hysteresis codes, then output edges and sticky flags.
		wr(8'h9E, 8'h30);
		wr(8'h9D, 8'h8C);
		chk({10'h000, cmp_b_pos_hysteresis}, 12'h003);
		chk({10'h000, cmp_b_neg_hysteresis}, 12'h000);
		wr(8'h9D, 8'h87);
		chk({10'h000, cmp_b_pos_hysteresis}, 12'h001);
		chk({10'h000, cmp_b_neg_hysteresis}, 12'h003);
		pos_gt_neg = 1'b1;
		idle(6);
		rd(8'h9D, 8'hE7);
		chk({11'h000, cmp_b_irq}, 12'h001);
		chk({11'h000, cmp_b_pin_out}, 12'h001);
		wr(8'h9D, 8'h80);
		rd(8'h9D, 8'hC0);
		chk({11'h000, cmp_b_irq}, 12'h000);
		pos_gt_neg = 1'b0;
		idle(6);
		rd(8'h9D, 8'h90);
		chk({11'h000, cmp_b_irq}, 12'h001);
		wr(8'h9E, 8'h20);
		idle(1);
		chk({11'h000, cmp_b_irq}, 12'h000);
		wr(8'h9D, 8'h80);
		pos_gt_neg = 1'b1;
		idle(6);
		chk({11'h000, cmp_b_irq}, 12'h001);
		wr(8'h9E, 8'h10);
		idle(1);
		chk({11'h000, cmp_b_irq}, 12'h000);
		$display("Test comparator B edges done");

		// Disabling drops the output; the written status bit stays read-only.
		wr(8'h9D, 8'h4B);
		idle(6);
		chk({11'h000, cmp_b_enable}, 12'h000);
		chk({11'h000, cmp_b_pin_out}, 12'h000);
		rd(8'h9D, 8'h1B);
		$display("Test comparator B disable done");
		close_out();
	end
endmodule // test_cmpc_regs
